// [verilog/vtg_pkg.sv]
package vtg_pkg;

	// Clock period of ref_clk in picoseconds
	localparam int CLK_PS = 4000;

	// Documented times, in nanoseconds
	localparam int T_XG_SETUP_NS  = 12;  // Gate leads row strobe fall
	localparam int T_XG_RAS_NS    = 140; // Gate held after row strobe fall
	localparam int T_XG_CAS_NS    = 55;  // Gate held after column strobe fall
	localparam int T_XG_RRISE_NS  = 39;  // Gate release before row rise
	localparam int T_XG_CRISE_NS  = 40;  // Gate release before column rise
	localparam int T_ROW_HOLD_NS  = 35;  // Row address hold after row fall
	localparam int T_RAS_CAS_NS   = 65;  // Row fall to column fall
	localparam int T_CODE_HOLD_NS = 65;  // Offset code hold after row fall
	localparam int T_PULSE_NS     = 40;  // Optional phase low pulse width
	localparam int T_PULSE_END_NS = 90;  // Gate release to pulse end
	localparam int T_PULSE_GAP_NS = 90;  // Pulse end to first byte strobe
	localparam int T_REF_CAS_NS   = 37;  // Column fall before row fall
	localparam int T_REF_HOLD_NS  = 185; // Column held after row fall
	localparam int T_PRECH_NS     = 100; // Precharge between cycles
	localparam int T_BYTE_NS      = 50;  // Video byte strobe period

	// Least times round up to whole cycles
	localparam logic [7:0] XG_SETUP_C =
		8'((T_XG_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] ROW_HOLD_C =
		8'((T_ROW_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RAS_CAS_C =
		8'((T_RAS_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] CODE_HOLD_C =
		8'((T_CODE_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XG_RAS_C =
		8'((T_XG_RAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XG_CAS_C =
		8'((T_XG_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XG_RRISE_C =
		8'((T_XG_RRISE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XG_CRISE_C =
		8'((T_XG_CRISE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] PULSE_C =
		8'((T_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] PULSE_END_C =
		8'((T_PULSE_END_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] PULSE_GAP_C =
		8'((T_PULSE_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] REF_CAS_C =
		8'((T_REF_CAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] REF_HOLD_C =
		8'((T_REF_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] PRECH_C =
		8'((T_PRECH_NS * 1000 + CLK_PS - 1) / CLK_PS);
	// Byte period rounds up so the strobe never runs faster than 50 ns
	localparam logic [7:0] BYTE_C =
		8'((T_BYTE_NS * 1000 + CLK_PS - 1) / CLK_PS);

	// Gate release point after row fall: later of the two hold times
	localparam logic [7:0] XG_REL_C =
		(XG_RAS_C > RAS_CAS_C + XG_CAS_C) ? XG_RAS_C
		                                  : 8'(RAS_CAS_C + XG_CAS_C);
	// Strobe rise after gate release: later of the two
	localparam logic [7:0] RISE_C =
		(XG_RRISE_C > XG_CRISE_C) ? XG_RRISE_C : XG_CRISE_C;
	// Post-release schedule for the phase pulse and strobe hold-off
	localparam logic [7:0] PULSE_BEG_C = 8'(PULSE_END_C - PULSE_C);
	localparam logic [7:0] VID_OK_C    = 8'(PULSE_END_C + PULSE_GAP_C);

	// Reset values
	localparam logic [9:0] ADDR_RST = 10'h000;
	localparam logic [2:0] CODE_RST = 3'h0;
	localparam logic [3:0] WE_IDLE  = 4'hF;

	// Address field layout: bank select above the row or column
	localparam int BANK_LSB = 8;

	// Cycle sequencer states
	typedef enum logic [2:0] {
		VTG_IDLE, VTG_XSET, VTG_XRAS, VTG_XREL,
		VTG_RCAS, VTG_RRAS, VTG_PRE
	} vtg_state_e;

endpackage

// [verilog/vtg_vbs_if.sv]
`timescale 1ns/1ps
interface vtg_vbs_if;
	logic run;     // Byte strobe allowed to run
	logic rise;    // One-cycle pulse on each strobe rising edge
	logic strobe;  // Byte strobe level

	modport gen  (input run, output rise, output strobe);
	modport user (output run, input rise, input strobe);
endinterface

// [verilog/vtg_byte_strobe.sv]
`timescale 1ns/1ps
// Byte strobe divider: one strobe period is PERIOD clock cycles
module vtg_byte_strobe #(
	parameter logic [7:0] PERIOD = vtg_pkg::BYTE_C
) (
	// Clock and reset
	input wire logic  ref_clk,
	input wire logic  rst_b,
	// Strobe side
	vtg_vbs_if.gen    vbs
);
	import vtg_pkg::*;

	logic [7:0] cnt_q, cnt_d;
	logic       stb_q, stb_d;
	logic       rise_q, rise_d;

	// High for the first half, low for the rest; stops low when not run
	always_comb begin
		cnt_d  = cnt_q;
		stb_d  = stb_q;
		rise_d = 1'b0;
		if (!vbs.run) begin
			cnt_d = 8'h00;
			stb_d = 1'b0;
		end else if (cnt_q == 8'h00) begin
			stb_d  = 1'b1;
			rise_d = 1'b1;
			cnt_d  = 8'(PERIOD - 8'h01);
		end else begin
			cnt_d = 8'(cnt_q - 8'h01);
			if (cnt_q == 8'(PERIOD >> 1))
				stb_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q  <= 8'h00;
			stb_q  <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			stb_q  <= stb_d;
			rise_q <= rise_d;
		end
	end

	assign vbs.strobe = stb_q;
	assign vbs.rise   = rise_q;
endmodule

// [verilog/vtg_display_ctl.sv]
`timescale 1ns/1ps
// Overview of operation
// - Transfer gate strobe goes low 12 ns before the row strobe falls.
// - Gate held 140 ns after row fall and 55 ns after column fall.
// - Gate released 39 ns before row rise, 40 ns before column rise.
// - Write enables stay high all transfer; no dummy transfers issued.
// - Start-offset code driven around row fall; load pulse latches it.
// - Each manager feeds control codes to its own four converters.
// - Phase high at transfer start and end; optional 40 ns low pulse.
// - Low pulse ends 90 ns after gate release, 90 ns before strobe.
// - Refresh is column-before-row: 37 ns lead, 185 ns hold.
// - Each byte strobe rise loads one byte and one 3-bit word.
// - Phase toggles on every byte strobe rise, within 10 ns.
module vtg_display_ctl
	import vtg_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Cycle requests from the drawing engine
	input  wire logic       shift_load_pulse_req,
	input  wire logic [7:0] shift_load_pulse_row,
	input  wire logic [7:0] shift_load_pulse_col,
	input  wire logic [1:0] shift_load_pulse_bank,
	input  wire logic [2:0] shift_load_pulse_offset,
	input  wire logic       refresh_req,
	output logic            busy,
	// Configuration and pixel control
	input  wire logic       phase_pulse_en,
	input  wire logic       video_en,
	input  wire logic [2:0] ctl_word,
	// Display memory pins
	output logic [9:0]      mem_addr,
	output logic            row_strobe_n,
	output logic            col_strobe_n,
	output logic            transfer_gate_strobe_n,
	output logic [3:0]      write_enable_n,
	// Converter and serial pins
	output logic [2:0]      shift_control_code,
	output logic            serial_clock_phase,
	output logic            video_byte_strobe
);
	import vtg_pkg::*;

	vtg_vbs_if vbs ();

	vtg_state_e st_q, st_d;
	logic [7:0] cnt_q, cnt_d;
	logic [7:0] col_q, col_d;
	logic       ras_n_q, ras_n_d;
	logic       cas_n_q, cas_n_d;
	logic       xg_n_q, xg_n_d;
	logic [9:0] addr_q, addr_d;
	logic [2:0] code_q, code_d;
	logic       code_hold_q, code_hold_d;
	logic       busy_q, busy_d;
	logic [3:0] we_n_q;

	// Post-release scheduler for phase pulse and strobe hold-off
	logic [7:0] post_q, post_d;
	logic       post_run_q, post_run_d;
	logic       phase_q, phase_d;
	logic       vid_ok_q, vid_ok_d;
	logic       byte_pin_q, byte_pin_d;

	// Byte strobe divider, paused during and shortly after a transfer
	vtg_byte_strobe #(
		.PERIOD (BYTE_C)
	) u_vbs (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.vbs     (vbs.gen)
	);

	assign vbs.run = vid_ok_q & video_en;

	// Cycle sequencer: transfer and refresh timing
	always_comb begin
		st_d        = st_q;
		cnt_d       = cnt_q;
		col_d       = col_q;
		ras_n_d     = ras_n_q;
		cas_n_d     = cas_n_q;
		xg_n_d      = xg_n_q;
		addr_d      = addr_q;
		code_hold_d = code_hold_q;
		busy_d      = busy_q;
		case (st_q)
			VTG_IDLE: begin
				busy_d = 1'b0;
				if (shift_load_pulse_req) begin
					// Gate leads row fall; bank rides above the row
					xg_n_d      = 1'b0;
					addr_d      = {shift_load_pulse_bank, shift_load_pulse_row};
					col_d       = shift_load_pulse_col;
					code_hold_d = 1'b1;
					busy_d      = 1'b1;
					cnt_d       = 8'(XG_SETUP_C - 8'h01);
					st_d        = VTG_XSET;
				end else if (refresh_req) begin
					// Column strobe first marks a refresh cycle
					cas_n_d = 1'b0;
					busy_d  = 1'b1;
					cnt_d   = 8'(REF_CAS_C - 8'h01);
					st_d    = VTG_RCAS;
				end
			end
			VTG_XSET: begin
				if (cnt_q == 8'h00) begin
					ras_n_d = 1'b0;
					cnt_d   = 8'h00;
					st_d    = VTG_XRAS;
				end else begin
					cnt_d = 8'(cnt_q - 8'h01);
				end
			end
			VTG_XRAS: begin
				// Counts cycles since row fall
				cnt_d = 8'(cnt_q + 8'h01);
				if (cnt_q == 8'(ROW_HOLD_C - 8'h01))
					addr_d = {addr_q[9:BANK_LSB], col_q};
				if (cnt_q == 8'(RAS_CAS_C - 8'h01))
					cas_n_d = 1'b0;
				if (cnt_q == 8'(CODE_HOLD_C - 8'h01))
					code_hold_d = 1'b0;
				if (cnt_q == 8'(XG_REL_C - 8'h01)) begin
					xg_n_d = 1'b1;
					cnt_d  = 8'(RISE_C - 8'h01);
					st_d   = VTG_XREL;
				end
			end
			VTG_XREL: begin
				if (cnt_q == 8'h00) begin
					// Both strobes rise after the release margin
					ras_n_d = 1'b1;
					cas_n_d = 1'b1;
					cnt_d   = 8'(PRECH_C - 8'h01);
					st_d    = VTG_PRE;
				end else begin
					cnt_d = 8'(cnt_q - 8'h01);
				end
			end
			VTG_RCAS: begin
				if (cnt_q == 8'h00) begin
					ras_n_d = 1'b0;
					cnt_d   = 8'(REF_HOLD_C - 8'h01);
					st_d    = VTG_RRAS;
				end else begin
					cnt_d = 8'(cnt_q - 8'h01);
				end
			end
			VTG_RRAS: begin
				if (cnt_q == 8'h00) begin
					ras_n_d = 1'b1;
					cas_n_d = 1'b1;
					cnt_d   = 8'(PRECH_C - 8'h01);
					st_d    = VTG_PRE;
				end else begin
					cnt_d = 8'(cnt_q - 8'h01);
				end
			end
			VTG_PRE: begin
				// Precharge keeps back-to-back cycles apart
				if (cnt_q == 8'h00)
					st_d = VTG_IDLE;
				else
					cnt_d = 8'(cnt_q - 8'h01);
			end
			default: begin
				st_d    = VTG_IDLE;
				ras_n_d = 1'b1;
				cas_n_d = 1'b1;
				xg_n_d  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q        <= VTG_IDLE;
			cnt_q       <= 8'h00;
			col_q       <= 8'h00;
			ras_n_q     <= 1'b1;
			cas_n_q     <= 1'b1;
			xg_n_q      <= 1'b1;
			addr_q      <= ADDR_RST;
			code_hold_q <= 1'b0;
			busy_q      <= 1'b0;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			col_q       <= col_d;
			ras_n_q     <= ras_n_d;
			cas_n_q     <= cas_n_d;
			xg_n_q      <= xg_n_d;
			addr_q      <= addr_d;
			code_hold_q <= code_hold_d;
			busy_q      <= busy_d;
		end
	end

	// Only array-to-shifter transfers exist, so writes stay off here
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			we_n_q <= WE_IDLE;
		else
			we_n_q <= WE_IDLE;
	end

	// Phase and control code: pulse schedule, hold-off and byte toggling
	always_comb begin
		post_d     = post_q;
		post_run_d = post_run_q;
		phase_d    = phase_q;
		vid_ok_d   = vid_ok_q;
		code_d     = code_q;
		// Pin strobe may stay high but only rises with a phase toggle, so a
		// divider rise swallowed by a transfer start never reaches the pin
		byte_pin_d = vbs.strobe & byte_pin_q;
		if (st_q == VTG_IDLE && shift_load_pulse_req) begin
			// Phase parked high and strobes halted for the transfer
			phase_d    = 1'b1;
			vid_ok_d   = 1'b0;
			post_run_d = 1'b0;
			// Own offset code to own converters, latched by load pulse
			code_d     = shift_load_pulse_offset;
		end else if (st_q == VTG_XRAS && cnt_q == 8'(XG_REL_C - 8'h01)) begin
			post_d     = 8'h00;
			post_run_d = 1'b1;
		end else if (post_run_q) begin
			post_d = 8'(post_q + 8'h01);
			// Low pulse placed to end 90 ns after gate release
			if (phase_pulse_en && post_q == 8'(PULSE_BEG_C - 8'h01))
				phase_d = 1'b0;
			if (post_q == 8'(PULSE_END_C - 8'h01))
				phase_d = 1'b1;
			// First byte strobe no sooner than 90 ns after the pulse
			if (post_q == 8'(VID_OK_C - 8'h01)) begin
				vid_ok_d   = 1'b1;
				post_run_d = 1'b0;
			end
		end else if (vbs.rise && !code_hold_q) begin
			// Each strobe rise flips the phase and loads a new word
			phase_d    = ~phase_q;
			code_d     = ctl_word;
			byte_pin_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			post_q     <= 8'h00;
			post_run_q <= 1'b0;
			phase_q    <= 1'b1;
			vid_ok_q   <= 1'b0;
			code_q     <= CODE_RST;
		end else begin
			post_q     <= post_d;
			post_run_q <= post_run_d;
			phase_q    <= phase_d;
			vid_ok_q   <= vid_ok_d;
			code_q     <= code_d;
		end
	end

	// Pin strobe registered beside the phase so both move on one edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			byte_pin_q <= 1'b0;
		else
			byte_pin_q <= byte_pin_d;
	end

	// Pins straight from registers; phase_q trails strobe by 0 cycles
	assign busy                   = busy_q;
	assign mem_addr               = addr_q;
	assign row_strobe_n           = ras_n_q;
	assign col_strobe_n           = cas_n_q;
	assign transfer_gate_strobe_n = xg_n_q;
	assign write_enable_n         = we_n_q;
	assign shift_control_code     = code_q;
	assign serial_clock_phase     = phase_q;
	assign video_byte_strobe      = byte_pin_q;
endmodule

// [dv/vtg_display_ctl_asserts.sv]
`timescale 1ns/1ps
// Pin timing checks for the display controller
module vtg_display_ctl_asserts (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_b,
	// Configuration
	input wire logic       busy,
	input wire logic       phase_pulse_en,
	input wire logic [2:0] ctl_word,
	// Memory and converter pins
	input wire logic       row_strobe_n,
	input wire logic       col_strobe_n,
	input wire logic       transfer_gate_strobe_n,
	input wire logic [3:0] write_enable_n,
	input wire logic [2:0] shift_control_code,
	input wire logic       serial_clock_phase,
	input wire logic       video_byte_strobe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Transfer gate timing around the strobes, in 4 ns cycles
	a_gate_leads_row: assert property (
		$fell(row_strobe_n) && !transfer_gate_strobe_n
		|-> $past(transfer_gate_strobe_n, 3) == 1'b0)
		else $error("gate did not lead row strobe");
	a_gate_hold_row: assert property (
		$fell(row_strobe_n) && !transfer_gate_strobe_n
		|-> ##34 !transfer_gate_strobe_n)
		else $error("gate released early after row fall");
	a_gate_hold_col: assert property (
		$fell(col_strobe_n) && !transfer_gate_strobe_n
		|-> ##13 !transfer_gate_strobe_n)
		else $error("gate released early after column fall");
	a_gate_rel_early: assert property (
		$rose(transfer_gate_strobe_n)
		|-> ##9 (!row_strobe_n && !col_strobe_n))
		else $error("strobe rose too soon after gate");
	a_we_high: assert property (write_enable_n == 4'hF)
		else $error("write enable left high level");
	// Refresh: column strobe leads the row strobe fall and is held after it
	a_ref_cas_lead: assert property (
		$fell(row_strobe_n) && transfer_gate_strobe_n
		|-> $past(col_strobe_n, 10) == 1'b0)
		else $error("column strobe lead too short");
	a_ref_cas_hold: assert property (
		$fell(row_strobe_n) && transfer_gate_strobe_n
		|-> ##46 !col_strobe_n)
		else $error("column strobe hold too short");
	// Phase stays high at transfer start; pulse stays low for at least 8 cycles
	a_phase_high_shift_load_pulse: assert property (
		$fell(transfer_gate_strobe_n)
		|-> serial_clock_phase ##3 serial_clock_phase)
		else $error("phase low at transfer start");
	a_pulse_width: assert property (
		$fell(serial_clock_phase) && busy |-> !serial_clock_phase[*8])
		else $error("phase pulse too short");
	a_pulse_end: assert property (
		$rose(transfer_gate_strobe_n) && phase_pulse_en
		|-> !video_byte_strobe[*8] ##17 serial_clock_phase)
		else $error("phase pulse not ended in time");
	// Each byte strobe rise toggles the phase and loads the code
	a_phase_toggle: assert property (
		$rose(video_byte_strobe)
		|-> serial_clock_phase != $past(serial_clock_phase))
		else $error("phase did not toggle");
	a_code_load: assert property (
		$rose(video_byte_strobe) |-> shift_control_code == $past(ctl_word))
		else $error("code not loaded on strobe");

	cover property ($fell(row_strobe_n) && !transfer_gate_strobe_n);
	cover property ($fell(row_strobe_n) && transfer_gate_strobe_n);
	cover property ($rose(video_byte_strobe));
endmodule

bind vtg_display_ctl vtg_display_ctl_asserts chk_u (
	.ref_clk(ref_clk), .rst_b(rst_b), .busy(busy),
	.phase_pulse_en(phase_pulse_en), .ctl_word(ctl_word),
	.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
	.transfer_gate_strobe_n(transfer_gate_strobe_n),
	.write_enable_n(write_enable_n),
	.shift_control_code(shift_control_code),
	.serial_clock_phase(serial_clock_phase),
	.video_byte_strobe(video_byte_strobe)
);

// [dv/vtg_vram_model.sv]
`timescale 1ns/1ps
// Glue, bank decode and converter seen from the memory pins
module vtg_vram_model (
	// Memory and converter pins
	input wire logic       row_strobe_n,
	input wire logic       col_strobe_n,
	input wire logic       transfer_gate_strobe_n,
	input wire logic [9:0] mem_addr,
	input wire logic [2:0] shift_control_code,
	input wire logic       serial_clock_phase,
	input wire logic       video_byte_strobe,
	// Observed glue state
	output logic [1:0]     bank_q,
	output logic [2:0]     offset_q,
	output logic [3:0]     row_mask,
	output logic [3:0]     left_oe_n,
	output logic [3:0]     right_oe_n,
	output logic [3:0]     left_clk_n,
	output logic [3:0]     right_clk_n,
	output int             byte_cnt
);
	logic shift_load_pulse = 1'b0;
	initial bank_q = 2'h0;
	initial offset_q = 3'h0;
	initial row_mask = 4'hF;
	initial byte_cnt = 0;
	// Load pulse is the inverted gate seen at row fall
	always @(negedge row_strobe_n) begin
		shift_load_pulse <= ~transfer_gate_strobe_n;
		row_mask <= col_strobe_n ? ~(4'h1 << mem_addr[9:8]) : 4'h0;
	end
	always @(posedge row_strobe_n) shift_load_pulse <= 1'b0;
	// Bank and offset stay latched until the next transfer
	always @(posedge shift_load_pulse) begin
		bank_q <= mem_addr[9:8];
		offset_q <= shift_control_code;
	end
	// Enables steered by phase and bank; left and right complementary
	assign left_oe_n = ~({3'h0, serial_clock_phase} << bank_q);
	assign right_oe_n = ~({3'h0, !serial_clock_phase} << bank_q);
	// Right bank clock follows the phase, left clock is its inverse
	assign right_clk_n = ~({3'h0, !serial_clock_phase} << bank_q);
	assign left_clk_n = ~({3'h0, serial_clock_phase} << bank_q);
	// Converter takes one byte per strobe rise
	always @(posedge video_byte_strobe) byte_cnt <= byte_cnt + 1;
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
	import vtg_pkg::*;
	logic ref_clk = 1'b0, rst_b = 1'b0, shift_load_pulse_req = 1'b0, refresh_req = 1'b0;
	logic [7:0] shift_load_pulse_row = 8'h00, shift_load_pulse_col = 8'h00;
	logic [1:0] shift_load_pulse_bank = 2'h0, bank_q;
	logic [2:0] shift_load_pulse_offset = 3'h0, ctl_word = 3'h0, offset_q, shift_control_code;
	logic phase_pulse_en = 1'b0, video_en = 1'b0, busy;
	logic [9:0] mem_addr;
	logic row_strobe_n, col_strobe_n, transfer_gate_strobe_n;
	logic serial_clock_phase, video_byte_strobe;
	logic [3:0] write_enable_n, row_mask;
	logic [3:0] left_oe_n, right_oe_n, left_clk_n, right_clk_n;
	int errors = 0, total_checks = 0, cyc = 0, byte_cnt;

	vtg_display_ctl dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.shift_load_pulse_req(shift_load_pulse_req), .shift_load_pulse_row(shift_load_pulse_row), .shift_load_pulse_col(shift_load_pulse_col),
		.shift_load_pulse_bank(shift_load_pulse_bank), .shift_load_pulse_offset(shift_load_pulse_offset),
		.refresh_req(refresh_req), .busy(busy),
		.phase_pulse_en(phase_pulse_en), .video_en(video_en),
		.ctl_word(ctl_word), .mem_addr(mem_addr),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.transfer_gate_strobe_n(transfer_gate_strobe_n),
		.write_enable_n(write_enable_n),
		.shift_control_code(shift_control_code),
		.serial_clock_phase(serial_clock_phase),
		.video_byte_strobe(video_byte_strobe));
	vtg_vram_model model_u (.row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n),
		.transfer_gate_strobe_n(transfer_gate_strobe_n),
		.mem_addr(mem_addr), .shift_control_code(shift_control_code),
		.serial_clock_phase(serial_clock_phase),
		.video_byte_strobe(video_byte_strobe), .bank_q(bank_q),
		.offset_q(offset_q), .row_mask(row_mask), .left_oe_n(left_oe_n),
		.right_oe_n(right_oe_n), .left_clk_n(left_clk_n),
		.right_clk_n(right_clk_n), .byte_cnt(byte_cnt));

	always #2 ref_clk = ~ref_clk;
	// Hang guard, well above the few hundred cycles needed
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask
	// Inputs move 1 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic start(input logic x, input logic [1:0] b,
		input logic [2:0] o);
		int k;
		shift_load_pulse_req = x;
		refresh_req = !x;
		shift_load_pulse_bank = b;
		shift_load_pulse_offset = o;
		shift_load_pulse_row = {b, o, 3'h5};
		shift_load_pulse_col = ~shift_load_pulse_row;
		step(1);
		shift_load_pulse_req = 1'b0;
		refresh_req = 1'b0;
		step(1);
		k = 0;
		while (busy !== 1'b0 && k < 200) begin
			step(1);
			k++;
			// A request while busy must be ignored
			if (k == 10) shift_load_pulse_req = 1'b1;
			if (k == 11) shift_load_pulse_req = 1'b0;
		end
		check(busy, 10'h000, "busy stuck");
	endtask

	task automatic t_reset;
		check({row_strobe_n, col_strobe_n, transfer_gate_strobe_n,
			write_enable_n, serial_clock_phase, video_byte_strobe, busy},
			10'h3FC, "idle pins");
		check(bank_q, 10'h000, "bank latch not cleared");
	endtask
	task automatic t_shift_load_pulse_all;
		for (int b = 0; b < 4; b++) begin
			start(1'b1, 2'(b), 3'(2 * b + 1));
			check(bank_q, 10'(b), "bank latch");
			check(offset_q, 10'(2 * b + 1), "offset code");
			check(row_mask, {6'h00, ~(4'h1 << b)}, "bank row strobe");
		end
	endtask
	task automatic t_refresh;
		start(1'b0, 2'h0, 3'h7);
		check(row_mask, 10'h000, "refresh not all banks");
		check(bank_q, 10'h003, "refresh moved bank latch");
	endtask
	task automatic t_video;
		int k, last_low, n0;
		phase_pulse_en = 1'b1;
		video_en = 1'b1;
		ctl_word = 3'h5;
		shift_load_pulse_bank = 2'h2;
		shift_load_pulse_req = 1'b1;
		step(1);
		shift_load_pulse_req = 1'b0;
		k = 0;
		while (transfer_gate_strobe_n !== 1'b0 && k < 50) begin
			step(1);
			k++;
		end
		while (transfer_gate_strobe_n !== 1'b1 && k < 99) begin
			step(1);
			k++;
		end
		// Phase still high: left byte of bank 2 enabled, right clock idle
		check(bank_q, 10'h002, "video bank latch");
		check(left_oe_n, 10'h00B, "left byte not enabled");
		check(right_oe_n, 10'h00F, "right byte enabled early");
		check(right_clk_n, 10'h00F, "right clock not phase");
		check(left_clk_n, 10'h00B, "left clock not inverse");
		// Count from gate release to the first byte strobe
		k = 0;
		last_low = -1;
		while (video_byte_strobe !== 1'b1 && k < 200) begin
			if (serial_clock_phase === 1'b0) last_low = k;
			step(1);
			k++;
		end
		check(10'(last_low >= 22), 10'h001, "pulse ended early");
		check(10'(k - last_low >= 23), 10'h001, "strobe too soon");
		n0 = byte_cnt;
		// First strobe took the left byte; right byte now enabled
		check(right_oe_n, 10'h00B, "right byte not enabled");
		check(left_oe_n, 10'h00F, "left byte still enabled");
		check(right_clk_n, 10'h00B, "right clock not phase");
		for (int i = 0; i < 6; i++) begin
			logic p;
			p = serial_clock_phase;
			k = 0;
			while (video_byte_strobe !== 1'b0 && k < 30) begin
				step(1);
				k++;
			end
			while (video_byte_strobe !== 1'b1 && k < 60) begin
				step(1);
				k++;
			end
			check(serial_clock_phase, 10'(!p), "phase not toggled");
			check(shift_control_code, 10'(ctl_word), "code");
			ctl_word = ctl_word + 3'h3;
		end
		check(10'(byte_cnt - n0), 10'h006, "byte count");
		video_en = 1'b0;
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		step(3);
		rst_b = 1'b1;
		t_reset();
		t_shift_load_pulse_all();
		t_refresh();
		t_video();
		close_out();
	end
endmodule
